// >>> can_node_supervision_consts.svh
// Register offsets, widths and timing counts for the node supervision block
`ifndef CAN_NODE_SUPERVISION_CONSTS_SVH
`define CAN_NODE_SUPERVISION_CONSTS_SVH
`define OFS_PDO_SEND_TRIGGER 9'h108
`define OFS_HEARTBEAT_PERIOD_MS 9'h10C
`define OFS_GUARD_REQUEST_PERIOD_MS 9'h10D
`define OFS_GUARD_LIFETIME_MULTIPLIER 9'h10E
`define PDO_TRIGGER_TYPE_CODE 8'hFE
`define RST_HEARTBEAT_PERIOD_MS 16'h0000
`define RST_GUARD_REQUEST_PERIOD_MS 16'h0000
`define RST_GUARD_LIFETIME_MULTIPLIER 8'h00
`define MS_TIME_NS 1000000
`define CLK_PERIOD_NS 4
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)
`endif

// >>> can_node_supervision_pkg.sv
// Types for the node supervision block
package can_node_supervision_pkg;
    typedef enum logic [1:0] {sup_off, sup_heartbeat, sup_guard} sup_mode_e;
endpackage

// >>> can_node_supervision.sv
// Heartbeat, node guarding supervision and PDO trigger logic
// Notes on behaviour
// - Any trigger write sends type 254 PDOs
// - Trigger reads send nothing, return zero
// - Heartbeat every heartbeat period milliseconds
// - Zero heartbeat period stops heartbeats
// - Only one supervision method runs
// - Nonzero heartbeat overrides guarding settings
// - Answer each guard request outside heartbeat mode with state
// - Timeout is guard period times multiplier
// - Missing request within timeout raises fault
`include "can_node_supervision_consts.svh"
module can_node_supervision
    import can_node_supervision_pkg::*;
#(
    parameter int MS_CYCLES = `MS_CYCLES
)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic guard_request,
    input wire logic [6:0] node_state,
    output logic heartbeat_send,
    output logic guard_reply_send,
    output logic [6:0] reply_state,
    output logic pdo_trigger_send,
    output logic [7:0] pdo_trigger_type,
    output logic guard_fault
);
    logic [15:0] heartbeat_period_ms_reg;
    logic [15:0] guard_request_period_ms_reg;
    logic [7:0] guard_lifetime_multiplier_reg;
    logic [31:0] tick_cnt_reg;
    logic [15:0] hb_ms_reg;
    logic [23:0] guard_ms_reg;
    logic ms_tick;
    sup_mode_e mode;

    // Offset match, shared by every register decode
    function automatic logic addr_is(input logic [8:0] addr, input logic [8:0] ofs);
    begin
        return addr == ofs;
    end
    endfunction

    // Last unit of a period; looks one ahead so a count never passes its limit
    function automatic logic period_done(input logic [31:0] count, input logic [31:0] limit);
    begin
        return count + 32'h00000001 >= limit;
    end
    endfunction

    // Heartbeat wins over guarding, whatever the guarding settings hold
    function automatic sup_mode_e pick_mode(input logic hb, input logic guard);
    begin
        if (hb)
            return sup_heartbeat;
        else if (guard)
            return sup_guard;
        else
            return sup_off;
    end
    endfunction

    wire logic sel_trig = addr_is(reg_addr, `OFS_PDO_SEND_TRIGGER);
    wire logic sel_hb = addr_is(reg_addr, `OFS_HEARTBEAT_PERIOD_MS);
    wire logic sel_gp = addr_is(reg_addr, `OFS_GUARD_REQUEST_PERIOD_MS);
    wire logic sel_lm = addr_is(reg_addr, `OFS_GUARD_LIFETIME_MULTIPLIER);
    // Only writes reach the trigger; a read of its offset has no side effect
    wire logic wr_trig = reg_wr && sel_trig;
    wire logic wr_hb = reg_wr && sel_hb;
    wire logic wr_gp = reg_wr && sel_gp;
    wire logic wr_lm = reg_wr && sel_lm;
    // Timeout product, widened so 16x8 bits never wraps
    wire logic [23:0] guard_timeout_ms = {8'h00, guard_request_period_ms_reg}
        * {16'h0000, guard_lifetime_multiplier_reg};
    wire logic hb_on = heartbeat_period_ms_reg != 16'h0000;
    wire logic guard_on = !hb_on && guard_timeout_ms != 24'h000000;
    wire logic hb_mode = mode == sup_heartbeat;
    wire logic guard_mode = mode == sup_guard;
    wire logic hb_wrap = period_done({16'h0000, hb_ms_reg},
        {16'h0000, heartbeat_period_ms_reg});
    wire logic [15:0] hb_ms_inc = hb_ms_reg + 16'h0001;
    wire logic hb_due = hb_mode && ms_tick && hb_wrap;
    // Fault a full tick after the count reaches the timeout: late by at most 1 ms, never early
    wire logic guard_expired = guard_ms_reg >= guard_timeout_ms;
    wire logic [23:0] guard_ms_inc = guard_ms_reg + 24'h000001;
    wire logic guard_clear = !guard_mode || guard_request;
    // Requests under heartbeat get no answer
    wire logic reply_ok = guard_request && !hb_mode;
    wire logic [31:0] tick_inc = tick_cnt_reg + 32'h00000001;
    assign ms_tick = period_done(tick_cnt_reg, 32'(MS_CYCLES));
    assign mode = pick_mode(hb_on, guard_on);
    // Trigger offset reads zero; it holds no state
    wire logic [15:0] rd_mux = sel_hb ? heartbeat_period_ms_reg
        : sel_gp ? guard_request_period_ms_reg
        : sel_lm ? {8'h00, guard_lifetime_multiplier_reg}
        : 16'h0000;
    wire logic [15:0] rd_word = reg_rd ? rd_mux : 16'h0000;

    always_ff @(posedge mclk)
    begin
        if (srst)
            heartbeat_period_ms_reg <= `RST_HEARTBEAT_PERIOD_MS;
        else if (wr_hb)
            heartbeat_period_ms_reg <= reg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            guard_request_period_ms_reg <= `RST_GUARD_REQUEST_PERIOD_MS;
        else if (wr_gp)
            guard_request_period_ms_reg <= reg_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            guard_lifetime_multiplier_reg <= `RST_GUARD_LIFETIME_MULTIPLIER;
        else if (wr_lm)
            guard_lifetime_multiplier_reg <= reg_wdata[7:0];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            reg_rvalid <= 1'b0;
        else
            reg_rvalid <= reg_rd;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= rd_word;
    end

    // One shared millisecond prescaler; windows start mid-millisecond
    always_ff @(posedge mclk)
    begin
        if (srst || ms_tick)
            tick_cnt_reg <= 32'h00000000;
        else
            tick_cnt_reg <= tick_inc;
    end

    // Heartbeat counter restarts on a period write so the new period applies at once
    always_ff @(posedge mclk)
    begin
        if (srst || wr_hb || !hb_mode)
            hb_ms_reg <= 16'h0000;
        else if (ms_tick && hb_wrap)
            hb_ms_reg <= 16'h0000;
        else if (ms_tick)
            hb_ms_reg <= hb_ms_inc;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            heartbeat_send <= 1'b0;
        else
            heartbeat_send <= hb_due;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            guard_reply_send <= 1'b0;
        else
            guard_reply_send <= reply_ok;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            reply_state <= 7'h00;
        else if (guard_request)
            reply_state <= node_state;
    end

    // Count saturates at the timeout, so a long silence cannot wrap it back
    always_ff @(posedge mclk)
    begin
        if (srst || guard_clear)
            guard_ms_reg <= 24'h000000;
        else if (ms_tick && !guard_expired)
            guard_ms_reg <= guard_ms_inc;
    end

    // Fault sticks until a request arrives or guarding is disabled
    always_ff @(posedge mclk)
    begin
        if (srst || guard_clear)
            guard_fault <= 1'b0;
        else if (ms_tick && guard_expired)
            guard_fault <= 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            pdo_trigger_send <= 1'b0;
        else
            pdo_trigger_send <= wr_trig;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            pdo_trigger_type <= 8'h00;
        else
            pdo_trigger_type <= `PDO_TRIGGER_TYPE_CODE;
    end
endmodule

// >>> sup_chk_checker.sv
// Checker for the node supervision block
`include "can_node_supervision_consts.svh"
module sup_chk
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [8:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic guard_request,
    input wire logic heartbeat_send,
    input wire logic guard_reply_send,
    input wire logic pdo_trigger_send,
    input wire logic guard_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] hb_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Heartbeat period shadow, the mode decides everything
    always_ff @(posedge mclk)
        hb_reg <= srst ? 16'h0 : (reg_wr && reg_addr == `OFS_HEARTBEAT_PERIOD_MS) ? reg_wdata
            : hb_reg;
    property p_tr; reg_wr && reg_addr == `OFS_PDO_SEND_TRIGGER |=> pdo_trigger_send; endproperty
    a_tr: assert property (p_tr) else $error("trigger missing");
    property p_on; pdo_trigger_send |-> $past(reg_wr && reg_addr == `OFS_PDO_SEND_TRIGGER);
    endproperty
    a_on: assert property (p_on) else $error("stray trigger");
    property p_rz; reg_rvalid && $past(reg_addr) == `OFS_PDO_SEND_TRIGGER |-> reg_rdata == 16'h0;
    endproperty
    a_rz: assert property (p_rz) else $error("trigger read");
    property p_hz; hb_reg == 16'h0 && $past(hb_reg) == 16'h0 |-> !heartbeat_send; endproperty
    a_hz: assert property (p_hz) else $error("heartbeat off");
    property p_hg; heartbeat_send |=> !heartbeat_send [*8]; endproperty
    a_hg: assert property (p_hg) else $error("heartbeat gap");
    property p_rp; guard_request && hb_reg == 16'h0 |=> guard_reply_send; endproperty
    a_rp: assert property (p_rp) else $error("no reply");
    property p_nr; guard_request && hb_reg != 16'h0 |=> !guard_reply_send; endproperty
    a_nr: assert property (p_nr) else $error("reply in heartbeat");
    property p_fh; guard_fault |-> $past(hb_reg, 2) == 16'h0; endproperty
    a_fh: assert property (p_fh) else $error("fault in heartbeat");
endmodule
bind can_node_supervision sup_chk i_sup_chk (
    .mclk(mclk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .guard_request(guard_request),
    .heartbeat_send(heartbeat_send),
    .guard_reply_send(guard_reply_send),
    .pdo_trigger_send(pdo_trigger_send),
    .guard_fault(guard_fault)
);

// >>> guard_master.sv
// Network master sending guarding requests
module guard_master
#(
    parameter int PERIOD = 10
)
(
    input wire logic mclk,
    input wire logic run,
    output logic req = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    always @(negedge mclk)
    begin
        n = run ? n + 1 : 0;
        // One request per guard period, in clock cycles
        req <= run && n >= PERIOD;
        if (n >= PERIOD)
            n = 0;
    end
endmodule

// >>> can_node_supervision_tb_top.sv
// Self-checking bench for the node supervision block
`include "can_node_supervision_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module can_node_supervision_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, run = 0, guard_request, heartbeat_send;
    logic guard_reply_send, reg_rvalid, pdo_trigger_send, guard_fault;
    logic [8:0] reg_addr = 9'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, m_hb = 16'h0;
    logic [6:0] node_state = 7'h0, reply_state, exp_state = 7'h0;
    logic [7:0] pdo_trigger_type;
    int bad_count = 0, cmp_count = 0, t, nexp = 0, nrp = 0;
    longint q[$];
    always #2 mclk = ~mclk;
    can_node_supervision #(.MS_CYCLES(MS)) i_can_node_supervision (
        .mclk(mclk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .guard_request(guard_request),
        .node_state(node_state),
        .heartbeat_send(heartbeat_send),
        .guard_reply_send(guard_reply_send),
        .reply_state(reply_state),
        .pdo_trigger_send(pdo_trigger_send),
        .pdo_trigger_type(pdo_trigger_type),
        .guard_fault(guard_fault)
    );
    guard_master #(.PERIOD(MS)) i_guard_master (.mclk(mclk), .run(run), .req(guard_request));
    // Model: every request taken outside heartbeat mode owes one reply with the state
    always @(posedge mclk)
    begin
        if (guard_request && !srst)
        begin
            exp_state = node_state;
            nexp += (m_hb == 16'h0000);
        end
    end
    always @(negedge mclk)
    begin
        node_state = 7'($urandom);
        if (heartbeat_send)
            q.push_back($time);
        if (guard_reply_send)
            `CHK(reply_state, exp_state)
        nrp += guard_reply_send;
    end
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge mclk) reg_wr = 0;
        if (a == `OFS_HEARTBEAT_PERIOD_MS)
            m_hb = d;
    endtask
    task automatic rc(input logic [8:0] a, input logic [15:0] e);
        @(negedge mclk) {reg_rd, reg_addr} = {1'b1, a};
        @(negedge mclk) reg_rd = 0;
        `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
    endtask
    task automatic stop_test;
        $display("bad %0d of %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #20000 bad_count++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'h81e4));
        repeat (5) @(negedge mclk);
        srst = 0;
        @(negedge mclk);
        `CHK({heartbeat_send, guard_reply_send, pdo_trigger_send, guard_fault}, 4'h0)
        `CHK(pdo_trigger_type, `PDO_TRIGGER_TYPE_CODE)
        for (int a = 12; a < 15; a++)
        begin
            t = $urandom;
            wr(9'h100 + 9'(a), 16'(t));
            rc(9'h100 + 9'(a), a == 14 ? 16'(t) & 16'hFF : 16'(t));
        end
        rc(`OFS_PDO_SEND_TRIGGER, 16'h0);
        `CHK(pdo_trigger_send, 1'b0)
        rc(9'h1FF, 16'h0);
        wr(`OFS_PDO_SEND_TRIGGER, 16'($urandom));
        `CHK({pdo_trigger_send, pdo_trigger_type}, 9'h1FE)
        $display("registers done");
        wr(`OFS_HEARTBEAT_PERIOD_MS, 16'h2);
        @(negedge mclk);
        q.delete();
        repeat (70) @(negedge mclk);
        `CHK(q.size() >= 2, 1'b1)
        `CHK(q[1] - q[0], 2 * MS * 4)
        wr(`OFS_HEARTBEAT_PERIOD_MS, 16'h0);
        @(negedge mclk);
        q.delete();
        repeat (60) @(negedge mclk);
        `CHK(q.size(), 0)
        $display("heartbeat done");
        wr(9'h10D, 16'h1);
        wr(9'h10E, 16'h3);
        run = 1;
        repeat (200) @(negedge mclk);
        `CHK(guard_fault, 1'b0)
        @(posedge guard_request);
        @(negedge mclk) run = 0;
        repeat (3) @(negedge mclk);
        `CHK(nrp, nexp)
        repeat (15) @(negedge mclk);
        `CHK(guard_fault, 1'b0)
        repeat (25) @(negedge mclk);
        `CHK(guard_fault, 1'b1)
        wr(9'h10E, 16'h0);
        repeat (3) @(negedge mclk);
        `CHK(guard_fault, 1'b0)
        wr(9'h10E, 16'h3);
        wr(9'h10C, 16'h5);
        t = nrp;
        run = 1;
        repeat (100) @(negedge mclk);
        run = 0;
        repeat (3) @(negedge mclk);
        `CHK({guard_fault, nrp}, {1'b0, t})
        `CHK(nrp, nexp)
        $display("guarding done");
        stop_test();
    end
endmodule
